// ==== rtl/atp_cfg.v ====
// light threshold source, persistence and residual limit block with axi4-lite slave
`include "atp_defs.vh"

module atp_cfg (
    input  wire                    clk,
    input  wire                    rst,
    input  wire                    ce,

    input  wire [`ATP_ADDR_W-1:0]  s_axi_awaddr,
    input  wire                    s_axi_awvalid,
    output wire                    s_axi_awready,
    input  wire [31:0]             s_axi_wdata,
    input  wire [3:0]              s_axi_wstrb,
    input  wire                    s_axi_wvalid,
    output wire                    s_axi_wready,
    output reg  [1:0]              s_axi_bresp,
    output reg                     s_axi_bvalid,
    input  wire                    s_axi_bready,
    input  wire [`ATP_ADDR_W-1:0]  s_axi_araddr,
    input  wire                    s_axi_arvalid,
    output wire                    s_axi_arready,
    output reg  [31:0]             s_axi_rdata,
    output reg  [1:0]              s_axi_rresp,
    output reg                     s_axi_rvalid,
    input  wire                    s_axi_rready,

    input  wire [`ATP_SMP_W-1:0]   mod0_data,
    input  wire [`ATP_SMP_W-1:0]   mod1_data,
    input  wire [`ATP_SMP_W-1:0]   mod2_data,
    input  wire                    sample_valid,
    input  wire                    meas_restart,
    input  wire [`ATP_SMP_W-1:0]   light_low_threshold,
    input  wire [`ATP_SMP_W-1:0]   light_high_threshold,
    input  wire [`ATP_RES_W-1:0]   residual_request,
    input  wire [`ATP_CYC_W-1:0]   sample_cycles_base,

    output reg  [`ATP_RES_W-1:0]   residual_bits_r,
    output reg  [`ATP_CYC_W-1:0]   sample_cycles_r,
    output wire                    full_startup_per_sample,
    output wire                    light_thresh_event,
    output wire                    irq
);

// ****************************************
// configuration registers
// ****************************************
reg  [7:0]            src_pers_r;
reg  [7:0]            start_res_r;
reg  [`ATP_IRQ_W-1:0] irq_stat_r;
reg  [`ATP_IRQ_W-1:0] irq_en_r;
reg  [`ATP_IRQ_W-1:0] irq_stat_nxt;
reg  [`ATP_IRQ_W-1:0] irq_clr;
reg  [`ATP_IRQ_W-1:0] irq_evt;

wire [1:0]            threshold_source_select;
wire [3:0]            light_persistence_count;
wire [1:0]            residual_floor;
wire [1:0]            residual_ceiling;

assign threshold_source_select = src_pers_r[`ATP_SRC_LSB+1:`ATP_SRC_LSB];
assign light_persistence_count = src_pers_r[`ATP_PERS_LSB+3:`ATP_PERS_LSB];
assign full_startup_per_sample = start_res_r[`ATP_FULLST_BIT];
assign residual_floor          = start_res_r[`ATP_RFLOOR_LSB+1:`ATP_RFLOOR_LSB];
assign residual_ceiling        = start_res_r[`ATP_RCEIL_LSB+1:`ATP_RCEIL_LSB];

// ****************************************
// axi4-lite write channel
// ****************************************
reg                    aw_hold_r;
reg                    w_hold_r;
reg  [`ATP_ADDR_W-1:0] aw_addr_r;
reg  [7:0]             w_data_r;
reg                    w_lane0_r;
wire                   wr_go;
wire                   wr_hit;
wire [7:0]             wr_idx;

// address and data may arrive in either order; each is parked until both are here
assign s_axi_awready = ce & ~aw_hold_r & ~s_axi_bvalid;
assign s_axi_wready  = ce & ~w_hold_r & ~s_axi_bvalid;
assign wr_go         = ce & aw_hold_r & w_hold_r & ~s_axi_bvalid;
assign wr_idx        = aw_addr_r[9:2];

assign wr_hit = (aw_addr_r[11:10] == 2'h0) && (aw_addr_r[1:0] == 2'h0) &&
                ((wr_idx == `ATP_IDX_SRC_PERS) || (wr_idx == `ATP_IDX_START_RES) ||
                 (wr_idx == `ATP_IDX_IRQ_EN)   || (wr_idx == `ATP_IDX_IRQ_CLR)   ||
                 (wr_idx == `ATP_IDX_IRQ_STAT) || (wr_idx == `ATP_IDX_PCOUNT));

always @(posedge clk) begin
    if (rst) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        aw_addr_r    <= {`ATP_ADDR_W{1'b0}};
        w_data_r     <= 8'h00;
        w_lane0_r    <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= `ATP_RESP_OKAY;
    end else if (ce) begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r  <= 1'b1;
            w_data_r  <= s_axi_wdata[7:0];
            w_lane0_r <= s_axi_wstrb[0];
        end
        if (wr_go) begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `ATP_RESP_OKAY : `ATP_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ****************************************
// register writes
// ****************************************
// only byte lane 0 carries data; upper lanes are ignored since every register fits in 8 bits
wire wr_lane;

// a misaligned or unmapped address answers slverr and must not land in any register
assign wr_lane = wr_go & w_lane0_r & wr_hit;

always @(posedge clk) begin
    if (rst) begin
        src_pers_r  <= `ATP_SRC_PERS_RST;
        start_res_r <= `ATP_START_RES_RST; // [R8] [R9]
        irq_en_r    <= {`ATP_IRQ_W{1'b0}};
    end else if (ce && wr_lane) begin
        if (wr_idx == `ATP_IDX_SRC_PERS) begin
            src_pers_r <= w_data_r & `ATP_SRC_PERS_MASK;
        end
        // moving floor or ceiling off reset values leaves gains stale until recalibrated
        if (wr_idx == `ATP_IDX_START_RES) begin
            start_res_r <= w_data_r & `ATP_START_RES_MASK; // [R10]
        end
        if (wr_idx == `ATP_IDX_IRQ_EN) begin
            irq_en_r <= w_data_r[`ATP_IRQ_W-1:0];
        end
    end
end

// ****************************************
// axi4-lite read channel
// ****************************************
wire [7:0]  rd_idx;
reg  [31:0] rd_mux;
reg         rd_hit;
wire [5:0]  pcount;

assign s_axi_arready = ce & ~s_axi_rvalid;
assign rd_idx        = s_axi_araddr[9:2];

always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = (s_axi_araddr[11:10] == 2'h0) && (s_axi_araddr[1:0] == 2'h0);
    case (rd_idx)
        `ATP_IDX_SRC_PERS:  rd_mux[7:0] = src_pers_r;
        `ATP_IDX_START_RES: rd_mux[7:0] = start_res_r;
        `ATP_IDX_IRQ_STAT:  rd_mux[`ATP_IRQ_W-1:0] = irq_stat_r;
        `ATP_IDX_IRQ_EN:    rd_mux[`ATP_IRQ_W-1:0] = irq_en_r;
        `ATP_IDX_IRQ_CLR:   rd_mux = 32'h0000_0000;
        `ATP_IDX_PCOUNT:    rd_mux[5:0] = pcount;
        default:            rd_hit = 1'b0;
    endcase
    if (!rd_hit) begin
        rd_mux = 32'h0000_0000;
    end
end

always @(posedge clk) begin
    if (rst) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h0000_0000;
        s_axi_rresp  <= `ATP_RESP_OKAY;
    end else if (ce) begin
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? `ATP_RESP_OKAY : `ATP_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

// ****************************************
// threshold source and persistence
// ****************************************
wire [`ATP_SMP_W*3-1:0] mod_bus;
wire [2:0]              src_hot;
wire [`ATP_SMP_W*4-1:0] src_chain;
wire [`ATP_SMP_W-1:0]   src_smp;
wire                    pfire;

assign mod_bus    = {mod2_data, mod1_data, mod0_data};
// code 3 folds back onto channel 0 so every code picks exactly one source
assign src_hot[0] = (threshold_source_select == 2'h0) || (threshold_source_select == 2'h3); // [R1]
assign src_hot[1] = (threshold_source_select == 2'h1); // [R1]
assign src_hot[2] = (threshold_source_select == 2'h2); // [R1]
assign src_chain[`ATP_SMP_W-1:0] = {`ATP_SMP_W{1'b0}};

genvar ch;
generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_src
        assign src_chain[(ch+1)*`ATP_SMP_W +: `ATP_SMP_W] = src_chain[ch*`ATP_SMP_W +: `ATP_SMP_W] |
            (mod_bus[ch*`ATP_SMP_W +: `ATP_SMP_W] & {`ATP_SMP_W{src_hot[ch]}}); // [R1]
    end
endgenerate

assign src_smp = src_chain[3*`ATP_SMP_W +: `ATP_SMP_W];

atp_pfilt u_pfilt (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .restart (meas_restart),
    .smp_vld (sample_valid),
    .smp     (src_smp),
    .lo_thr  (light_low_threshold),
    .hi_thr  (light_high_threshold),
    .pers    (light_persistence_count),
    .fire_r  (pfire),
    .cnt_r   (pcount)
);

assign light_thresh_event = pfire; // [R3]

// ****************************************
// residual limits and startup timing
// ****************************************
reg  [`ATP_RES_W-1:0] res_floor_v;
reg  [`ATP_RES_W-1:0] res_ceil_v;
reg  [`ATP_RES_W-1:0] res_nxt;
reg  [`ATP_CYC_W-1:0] cyc_nxt;
reg                   clamp_evt_r;

always @* begin
    res_floor_v = {1'b0, residual_floor}; // [R8]
    res_ceil_v  = {1'b0, residual_ceiling} + 3'h1; // [R9]
    res_nxt     = residual_request;
    if (res_nxt < res_floor_v) begin
        res_nxt = res_floor_v; // [R8]
    end
    // with floor above ceiling the ceiling wins, keeping output within the hard maximum
    if (res_nxt > res_ceil_v) begin
        res_nxt = res_ceil_v; // [R9]
    end
end

always @* begin
    cyc_nxt = sample_cycles_base;
    if (full_startup_per_sample) begin
        if (sample_cycles_base > `ATP_STARTUP_SAVE) begin
            cyc_nxt = sample_cycles_base - `ATP_STARTUP_SAVE; // [R7]
        end else begin
            cyc_nxt = 16'h0001; // [R7]
        end
    end
end

always @(posedge clk) begin
    if (rst) begin
        residual_bits_r <= {`ATP_RES_W{1'b0}};
        sample_cycles_r <= 16'h0001;
        clamp_evt_r     <= 1'b0;
    end else if (ce) begin
        residual_bits_r <= res_nxt;
        sample_cycles_r <= cyc_nxt;
        clamp_evt_r     <= (res_nxt != residual_request) && sample_valid;
    end
end

// ****************************************
// interrupt status
// ****************************************
always @* begin
    irq_evt = {`ATP_IRQ_W{1'b0}};
    irq_evt[`ATP_IRQ_THRESH_BIT] = pfire;
    irq_evt[`ATP_IRQ_CLAMP_BIT]  = clamp_evt_r;
    irq_clr = {`ATP_IRQ_W{1'b0}};
    if (wr_lane && wr_idx == `ATP_IDX_IRQ_CLR) begin
        irq_clr = w_data_r[`ATP_IRQ_W-1:0];
    end
    // a new event in the clearing cycle survives the clear
    irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;
end

always @(posedge clk) begin
    if (rst) begin
        irq_stat_r <= {`ATP_IRQ_W{1'b0}};
    end else if (ce) begin
        irq_stat_r <= irq_stat_nxt;
    end
end

assign irq = |(irq_stat_r & irq_en_r); // [R3]

endmodule

// ==== rtl/atp_defs.vh ====
// constants for the light threshold persistence and residual limit block
// How it works
// [R1] source select 00/11 picks modulator 0, 01 modulator 1, 10 modulator 2
// [R2] a sample below the low or above the high threshold is out of range
// [R3] count consecutive out-of-range samples; interrupt once count reaches persistence target
// [R4] a sample inside the threshold window clears the counter to zero
// [R5] code 0 interrupts every sample; code 1 on any single out-of-range sample
// [R6] codes 2,3 need 2,3 samples; codes 4..15 need 5,10,... up to 60
// [R7] full startup option shortens each sample's measurement by 9 modulator cycles
// [R8] residual count held at or above floor field value 0..3, reset 0
// [R9] residual count held at or below ceiling field plus one, reset code 3
// [R10] software must force residual calibration after moving floor or ceiling off defaults
// [R11] counter cleared on reset and on each measurement restart
`ifndef ATP_DEFS_VH
`define ATP_DEFS_VH

// ****************************************
// bus and register map
// ****************************************
`define ATP_ADDR_W          12
`define ATP_IDX_SRC_PERS    8'ha6
`define ATP_IDX_START_RES   8'ha7
`define ATP_IDX_IRQ_STAT    8'hb8
`define ATP_IDX_IRQ_EN      8'hb9
`define ATP_IDX_IRQ_CLR     8'hba
`define ATP_IDX_PCOUNT      8'hbb
`define ATP_RESP_OKAY       2'h0
`define ATP_RESP_SLVERR     2'h2

// ****************************************
// fields and reset values
// ****************************************
`define ATP_SRC_LSB         4
`define ATP_PERS_LSB        0
`define ATP_FULLST_BIT      5
`define ATP_RFLOOR_LSB      2
`define ATP_RCEIL_LSB       0
`define ATP_SRC_PERS_MASK   8'h3f
`define ATP_START_RES_MASK  8'h2f
`define ATP_SRC_PERS_RST    8'h00
`define ATP_START_RES_RST   8'h03
`define ATP_IRQ_THRESH_BIT  0
`define ATP_IRQ_CLAMP_BIT   1
`define ATP_IRQ_W           2

// ****************************************
// data widths and counts
// ****************************************
`define ATP_SMP_W           16
`define ATP_CNT_W           6
`define ATP_RES_W           3
`define ATP_CYC_W           16
`define ATP_PERS_STEP       6'h05
`define ATP_PERS_LINEAR     4'h3
`define ATP_STARTUP_SAVE    16'h0009
`define ATP_CNT_MAX         6'h3f

`endif

// ==== rtl/atp_pfilt.v ====
// persistence filter: consecutive out-of-range counter and threshold fire
`include "atp_defs.vh"

module atp_pfilt (
    input  wire                    clk,
    input  wire                    rst,
    input  wire                    ce,
    input  wire                    restart,
    input  wire                    smp_vld,
    input  wire [`ATP_SMP_W-1:0]   smp,
    input  wire [`ATP_SMP_W-1:0]   lo_thr,
    input  wire [`ATP_SMP_W-1:0]   hi_thr,
    input  wire [3:0]              pers,
    output reg                     fire_r,
    output reg  [`ATP_CNT_W-1:0]   cnt_r
);

// ****************************************
// target and range check
// ****************************************
reg  [`ATP_CNT_W-1:0] target;
reg  [`ATP_CNT_W-1:0] cnt_nxt;
reg                   fire_nxt;
wire                  out_rng;

assign out_rng = (smp < lo_thr) || (smp > hi_thr); // [R2]

always @* begin
    if (pers <= `ATP_PERS_LINEAR) begin
        target = {2'h0, pers}; // [R6]
    end else begin
        target = `ATP_PERS_STEP * {2'h0, pers - `ATP_PERS_LINEAR}; // [R6]
    end
end

always @* begin
    cnt_nxt  = cnt_r;
    fire_nxt = 1'b0;
    if (restart) begin
        cnt_nxt = {`ATP_CNT_W{1'b0}}; // [R11]
    end else if (smp_vld) begin
        if (!out_rng) begin
            cnt_nxt = {`ATP_CNT_W{1'b0}}; // [R4]
        end else if (cnt_r != `ATP_CNT_MAX) begin
            cnt_nxt = cnt_r + 6'h01; // [R3]
        end
        // code 0 ignores the window for firing; the counter still follows it
        if (pers == 4'h0) begin
            fire_nxt = 1'b1; // [R5]
        end else if (out_rng && cnt_nxt >= target) begin
            fire_nxt = 1'b1; // [R3] [R5]
        end
    end
end

// ****************************************
// state
// ****************************************
always @(posedge clk) begin
    if (rst) begin
        cnt_r  <= {`ATP_CNT_W{1'b0}}; // [R11]
        fire_r <= 1'b0;
    end else if (ce) begin
        cnt_r  <= cnt_nxt;
        fire_r <= fire_nxt;
    end
end

endmodule

// ==== dv/atp_cfg_asserts.sv ====
// concurrent checks on the ports of the light threshold config block
module atp_cfg_asserts (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        sample_valid,
    input wire logic [15:0] sample_cycles_base,
    input wire logic [2:0]  residual_bits_r,
    input wire logic [15:0] sample_cycles_r,
    input wire logic        full_startup_per_sample,
    input wire logic        light_thresh_event
);
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_ready_freeze: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
        else $error("ready high while ce low");
    a_b_stands: assert property (s_axi_bvalid && !(s_axi_bready && ce) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_stands: assert property (s_axi_rvalid && !(s_axi_rready && ce) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
        else $error("read answer late");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_event_cause: assert property (light_thresh_event && $past(ce) |-> $past(sample_valid && ce))
        else $error("threshold event without sample");
    a_ceiling_cap: assert property (residual_bits_r <= 3'd4)
        else $error("residual count above top limit");
    a_cycles_cut: assert property (!$past(rst) && $past(ce) && $past(full_startup_per_sample)
        && $past(sample_cycles_base) > 16'd9 |-> sample_cycles_r == $past(sample_cycles_base) - 16'd9)
        else $error("full startup cycles wrong");
    a_cycles_pass: assert property (!$past(rst) && $past(ce) && !$past(full_startup_per_sample)
        && $past(sample_cycles_base) != 16'd0 |-> sample_cycles_r == $past(sample_cycles_base))
        else $error("nominal cycles wrong");

    c_event: cover property (light_thresh_event);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_fullst: cover property (full_startup_per_sample && sample_cycles_r == 16'd1);
endmodule

bind atp_cfg atp_cfg_asserts u_chk (.clk(clk), .rst(rst), .ce(ce), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sample_valid(sample_valid), .sample_cycles_base(sample_cycles_base), .residual_bits_r(residual_bits_r),
    .sample_cycles_r(sample_cycles_r), .full_startup_per_sample(full_startup_per_sample),
    .light_thresh_event(light_thresh_event));

// ==== dv/atp_cfg_tb.sv ====
// self-checking bench for the light threshold config block
module atp_cfg_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst = 1, ce = 1, sv = 0, mr = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0]  wstrb = 0;
    logic [1:0]  bresp, rresp;
    logic        bvalid, rvalid, awready, wready, arready, evt, irq, fs, ins, fire, full;
    logic [15:0] m [0:2];
    logic [15:0] lo = 16'h1000, hi = 16'h8000, base = 0, cyc, vi, vo;
    logic [2:0]  rreq = 0, rbits;
    int          error_cnt = 0, samples_checked = 0, code, i, k, src, cnt, tgt, e, b;

    atp_cfg dut (.clk(clk), .rst(rst), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mod0_data(m[0]), .mod1_data(m[1]),
        .mod2_data(m[2]), .sample_valid(sv), .meas_restart(mr), .light_low_threshold(lo),
        .light_high_threshold(hi), .residual_request(rreq), .sample_cycles_base(base),
        .residual_bits_r(rbits), .sample_cycles_r(cyc), .full_startup_per_sample(fs),
        .light_thresh_event(evt), .irq(irq));

    initial begin
        forever #25 clk = ~clk;
    end

    // ****************************************
    // bus and compare tasks
    // ****************************************
    task wrap_up();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // handshakes are judged at the falling edge, where inputs and ready are settled
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er, input logic [3:0] s = 4'hf);
        int n;
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid & bready;
            if (tb) chk(bresp, er);
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            // bready stays up between writes so no step lowers and raises it at once
            if (tb) begin
                break;
            end
        end
        if (n == 40) begin
            error_cnt++;
            wrap_up();
        end
    endtask

    task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic ta, tr;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            ta = arvalid & arready;
            tr = rvalid & rready;
            if (tr) chk(rdata, ed);
            if (tr) chk(rresp, er);
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                break;
            end
        end
        if (n == 40) begin
            error_cnt++;
            wrap_up();
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        m[0] = 0;
        m[1] = 0;
        m[2] = 0;
        void'($urandom(32'hd96c));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(12'h298, 32'h00, 2'h0);
        rd(12'h29c, 32'h03, 2'h0);
        wr(12'h29c, 32'hff, 2'h0, 4'he);
        rd(12'h29c, 32'h03, 2'h0);
        wr(12'h100, 32'h1, 2'h2);
        rd(12'h100, 32'h0, 2'h2);
        rd(12'h299, 32'h0, 2'h2);
        wr(12'h298, 32'hff, 2'h0);
        rd(12'h298, 32'h3f, 2'h0);
        wr(12'h299, 32'h15, 2'h2);
        rd(12'h298, 32'h3f, 2'h0);
        // out-of-range samples while ce is low must not move the counter
        ce <= 1'b0;
        sv <= 1'b1;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        sv <= 1'b0;
        rd(12'h2ec, 32'h0, 2'h0);
        wr(12'h2e4, 32'h1, 2'h0);
        for (code = 0; code < 16; code++) begin
            src = $urandom % 4;
            wr(12'h298, {src[1:0], code[3:0]}, 2'h0);
            mr <= 1'b1;
            @(posedge clk);
            mr <= 1'b0;
            cnt = 0;
            tgt = code == 0 ? 0 : code < 4 ? code : (code - 3) * 5;
            for (i = 0; i < 90; i++) begin
                if (i > 0 && i < 10 && $urandom % 4 == 0) begin
                    mr <= 1'b1;
                    @(posedge clk);
                    mr <= 1'b0;
                    cnt = 0;
                end
                ins = ($urandom % 6 == 0) && (i < 10 || i >= 75);
                k = $urandom % 3;
                vi = k == 0 ? lo : k == 1 ? hi : 16'h1000 + $urandom % 28672;
                vo = $urandom % 2 ? 16'h0fff - $urandom % 16 : 16'h8001 + $urandom % 16;
                for (k = 0; k < 3; k++) m[k] <= ((k == (src == 3 ? 0 : src)) == !ins) ? vo : vi;
                sv <= 1'b1;
                @(posedge clk);
                sv <= 1'b0;
                cnt = ins ? 0 : (cnt < 63 ? cnt + 1 : 63);
                fire = code == 0 || (!ins && cnt >= tgt);
                @(negedge clk);
                chk(evt, fire);
                @(posedge clk);
            end
            if (code != 0) rd(12'h2ec, cnt, 2'h0);
        end
        chk(irq, 1'b1);
        wr(12'h2e8, 32'h1, 2'h0);
        @(negedge clk);
        chk(irq, 1'b0);
        @(posedge clk);
        rd(12'h2e0, 32'h0, 2'h0);
        wr(12'h2e4, 32'h0, 2'h0);
        wr(12'h298, 32'h0, 2'h0);
        sv <= 1'b1;
        @(posedge clk);
        sv <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk(irq, 1'b0);
        @(posedge clk);
        rd(12'h2e0, 32'h1, 2'h0);
        for (k = 0; k < 16; k++) begin
            full = $urandom % 2;
            wr(12'h29c, {full, 1'b0, k[3:0]}, 2'h0);
            rreq <= $urandom % 8;
            b = k == 0 ? 9 : k == 1 ? 10 : 1 + $urandom % 4000;
            base <= b;
            @(posedge clk);
            @(negedge clk);
            e = rreq < k[3:2] ? k[3:2] : rreq;
            e = e > k[1:0] + 1 ? k[1:0] + 1 : e;
            chk(rbits, e);
            chk(cyc, full ? (b > 9 ? b - 9 : 1) : b);
            chk(fs, full);
            @(posedge clk);
        end
        // floor 3 above ceiling 1: a sample with request 0 is clamped and sets status bit 1
        wr(12'h29c, 32'h0c, 2'h0);
        rreq <= 3'h0;
        sv <= 1'b1;
        @(posedge clk);
        sv <= 1'b0;
        @(posedge clk);
        rd(12'h2e0, 32'h3, 2'h0);
        wrap_up();
    end
endmodule
